// ==== bwt_count_prescale.sv ====
// Divider that makes the prescaled count clock tick from the main clock.
`timescale 1ns/10ps
module bwt_count_prescale (
   input  wire logic       mclk,    // Main clock.
   input  wire logic       resetn,  // Asynchronous reset, active low.
   input  wire logic       run,     // Divider counts while high, cleared while low.
   input  wire logic [1:0] sel,     // Divide by two to the power sel.
   output logic            tick     // One-cycle count clock enable.
);
   import bwt_pkg::*;

   bwt_pre_state_type st;       // Registered state.
   bwt_pre_state_type next_st;  // Next state.
   logic [2:0]        mask;     // Low bits that must all be one for a tick.

   // The tick is combinational so the counter sees it in the same cycle.
   always_comb begin
      mask = 3'((4'h1 << sel) - 4'h1);
      tick = run && ((st.div & mask) == mask);
      next_st = st;
      if (!run) begin
         next_st.div = 3'h0;
      end else begin
         next_st.div = st.div + 3'h1;
      end
   end

   // Register the divider.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : bwt_count_prescale

// ==== bwt_defines.svh ====
// Register indices, field positions and reset values of the baud interval and watch timer.
`ifndef BWT_DEFINES_SVH
`define BWT_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define BWT_IDX_COMPARE    32'hfffff8b1
`define BWT_IDX_PRESCALE   32'hfffff8b0
`define BWT_IDX_WATCH_MODE 32'hfffff8b2
`define BWT_IDX_STATUS     32'hfffff8b3

// Reset values of the writable registers.
`define BWT_COMPARE_RESET  8'h00
`define BWT_PRESCALE_RESET 8'h00
`define BWT_WMODE_RESET    8'h00

// Prescale control fields.
`define BWT_CTL_SEL_LO     0
`define BWT_CTL_SEL_HI     1
`define BWT_CTL_GATE       4
`define BWT_CTL_EN         7
`define BWT_CTL_MASK       8'h93

// Watch mode control fields.
`define BWT_WM_ENABLE      0
`define BWT_WM_RUN         1
`define BWT_WM_PERIOD_LO   2
`define BWT_WM_PERIOD_HI   3
`define BWT_WM_ISEL_LO     4
`define BWT_WM_ISEL_HI     6
`define BWT_WM_SOURCE      7

// Counter reload value and the first interval tap exponent.
`define BWT_CNT_RELOAD     8'h01
`define BWT_TAP_BASE       4'h4
// Bits of the watch prescaler that make the divide-by-512 tap.
`define BWT_DIV512_MSB     8

`endif

// ==== bwt_pkg.sv ====
// Types shared by the baud interval and watch timer modules.
package bwt_pkg;

   // One-hot states of the main-clock interval timer.
   typedef enum logic [2:0] {
      BWT_ITV_IDLE = 3'b001,
      BWT_ITV_RUN  = 3'b010,
      BWT_ITV_HELD = 3'b100
   } bwt_itv_state_type;

   // Whole state of the timer top module.
   typedef struct packed {
      logic [7:0]        cmp;
      logic [7:0]        ctl;
      logic [7:0]        wmode;
      bwt_itv_state_type state;
      logic [7:0]        cnt;
      logic              brg_clk;
      logic [10:0]       wpre;
      logic [4:0]        wcnt;
      logic              irq_m;
      logic              irq_w;
      logic              irq_wi;
      logic [31:0]       prdata;
      logic              pslverr;
   } bwt_state_type;

   // Whole state of the count-clock prescaler.
   typedef struct packed {
      logic [2:0] div;
   } bwt_pre_state_type;

   // Reset image of the top module state.
   localparam bwt_state_type BWT_STATE_RESET = '{
      cmp:     8'h00,
      ctl:     8'h00,
      wmode:   8'h00,
      state:   BWT_ITV_IDLE,
      cnt:     8'h01,
      brg_clk: 1'b0,
      wpre:    11'h000,
      wcnt:    5'h00,
      irq_m:   1'b0,
      irq_w:   1'b0,
      irq_wi:  1'b0,
      prdata:  32'h00000000,
      pslverr: 1'b0
   };

endpackage : bwt_pkg

// ==== bwt_timer.sv ====
// Main-clock interval timer and watch timer with an APB register slave.
//
// Notes on behaviour
// - Eight-bit compare register, reset zero, byte wide.
// - Interval timer starts when enable bit set.
// - Match raises interrupt, reloads counter to one.
// - Period is two-power-m times N main clocks.
// - Compare zero means 256 counts.
// - Compare one interrupts only once.
// - Derived clock supplied when enabled and ungated.
// - Watch and interval interrupts run together.
// - Eleven-bit prescaler divides the watch clock.
// - Five-bit counter makes the watch interrupt.
// - Top mode bit selects watch clock source.
// - Bits 6..4 pick interval tap period.
// - Bits 3..2 pick watch interrupt period.
// - Mode bit 1 runs or clears counter.
// - Mode bit 0 enables, clearing stops everything.
// - Watch mode register eight bits, reset zero.
// - Counter advances on prescaled count clock.
// - Disable stops and clears interval counter.
// - Count starts only with both bits set.
`timescale 1ns/10ps
`include "bwt_defines.svh"
module bwt_timer #(
   parameter int PADDR_W = 12  // APB address width, at least twelve bits.
) (
   input  wire logic               mclk,                // Main clock, 100 MHz.
   input  wire logic               resetn,              // Asynchronous reset, active low.
   input  wire logic               psel,                // APB select.
   input  wire logic               penable,             // APB access phase.
   input  wire logic               pwrite,              // APB direction, high for write.
   input  wire logic [PADDR_W-1:0] paddr,               // APB byte address.
   input  wire logic [31:0]        pwdata,              // APB write data.
   input  wire logic [3:0]         pstrb,               // APB write byte strobes.
   input  wire logic               subclock_tick,       // One pulse per subclock period.
   output logic [31:0]             prdata,              // APB read data.
   output logic                    pready,              // APB ready.
   output logic                    pslverr,             // APB error.
   output logic                    interval_match_irq,  // Interval match pulse.
   output logic                    watch_irq,           // Watch period pulse.
   output logic                    watch_interval_irq,  // Watch interval pulse.
   output logic                    derived_main_clock   // Derived watch clock level.
);
   import bwt_pkg::*;

   bwt_state_type st;       // Registered state of the whole block.
   bwt_state_type next_st;  // Next state.

   logic       itv_tick;    // Prescaled count clock enable.
   logic       itv_run;     // Interval timer is out of idle and enabled.
   logic       ctl_en;      // Interval enable bit.
   logic       supply;      // Derived clock goes to the watch timer.
   logic       match;       // Counter meets compare on a count tick.
   logic       brg_rise;    // Rising edge of the derived clock.
   logic       wtick;       // One watch clock period has passed.
   logic       tap_hit;     // Watch interval tap reached.
   logic       div512;      // Watch clock divided by 512.
   logic       cnt_tick;    // Count clock of the five-bit counter.
   logic       wr_any;      // APB write in its access phase.
   logic       rd_setup;    // APB setup phase, read data prepared here.
   logic [3:0] tap_sh;      // Exponent of the interval tap.
   logic [10:0] tap_mask;   // Prescaler bits that must all be one.

   // Decide whether a byte address falls on the word of a register index.
   function automatic logic bwt_hit(input logic [PADDR_W-1:0] addr,
                                    input logic [31:0]        idx);
      bwt_hit = (addr[PADDR_W-1:2] == idx[PADDR_W-3:0]);
   endfunction : bwt_hit

   // Low bits of the watch prescaler for a tap of two to the power sh.
   function automatic logic [10:0] bwt_tap_mask(input logic [3:0] sh);
      logic [11:0] one;
      one = 12'h001 << sh;
      bwt_tap_mask = 11'(one - 12'h001);
   endfunction : bwt_tap_mask

   bwt_count_prescale u_prescale (
      .mclk   (mclk),
      .resetn (resetn),
      .run    (itv_run),
      .sel    ({st.ctl[`BWT_CTL_SEL_HI], st.ctl[`BWT_CTL_SEL_LO]}),
      .tick   (itv_tick)
   );

   // Every access completes without wait states.
   assign pready             = 1'b1;
   assign prdata             = st.prdata;
   assign pslverr            = st.pslverr;
   assign interval_match_irq = st.irq_m;
   assign watch_irq          = st.irq_w;
   assign watch_interval_irq = st.irq_wi;
   assign derived_main_clock = st.brg_clk;

   // All next-state logic of the block except the count-clock divider in u_prescale, in one place.
   always_comb begin
      next_st  = st;
      ctl_en   = st.ctl[`BWT_CTL_EN];
      itv_run  = ctl_en && (st.state != BWT_ITV_IDLE);
      wr_any   = psel && penable && pwrite && pstrb[0];
      rd_setup = psel && !penable;
      // Interrupt outputs are pulses, so they fall unless an event holds them.
      // single-cycle pulses
      next_st.irq_m  = 1'b0;
      next_st.irq_w  = 1'b0;
      next_st.irq_wi = 1'b0;

      // Register writes land at the access phase only.
      // compare register write
      if (wr_any && bwt_hit(paddr, `BWT_IDX_COMPARE)) begin
         next_st.cmp = pwdata[7:0];
      end
      // Reserved control bits are dropped so they read as zero.
      if (wr_any && bwt_hit(paddr, `BWT_IDX_PRESCALE)) begin
         next_st.ctl = pwdata[7:0] & `BWT_CTL_MASK;
      end
      if (wr_any && bwt_hit(paddr, `BWT_IDX_WATCH_MODE)) begin
         next_st.wmode = pwdata[7:0];
      end

      // A match compares the current count; 255 rolls to 0 so compare zero
      // stands for 256 counts without a ninth counter bit.
      // zero means 256
      match = itv_tick && (st.cnt == st.cmp);

      // Interval timer sequence.
      case (st.state)
         BWT_ITV_IDLE: begin
            next_st.cnt = `BWT_CNT_RELOAD;
            if (ctl_en) begin
               next_st.state = BWT_ITV_RUN;
            end
         end
         BWT_ITV_RUN, BWT_ITV_HELD: begin
            if (!ctl_en) begin
               next_st.state = BWT_ITV_IDLE;
               next_st.cnt   = `BWT_CNT_RELOAD;
            end else if (match) begin
               next_st.cnt = `BWT_CNT_RELOAD;
               if (st.state == BWT_ITV_RUN) begin
                  next_st.irq_m = 1'b1;
               end
               if ((st.state == BWT_ITV_RUN) && (st.cmp == 8'h01)) begin
                  next_st.state = BWT_ITV_HELD;
               end
            end else if (itv_tick) begin
               next_st.cnt = st.cnt + 8'h01;
            end
         end
         default: begin
            next_st.state = BWT_ITV_IDLE;
            next_st.cnt   = `BWT_CNT_RELOAD;
         end
      endcase

      // The derived clock toggles on every match, so one period spans two
      // interval periods; compare one keeps toggling though its irq stops.
      // derived clock supply
      supply   = ctl_en && !st.ctl[`BWT_CTL_GATE] && (st.state != BWT_ITV_IDLE);
      brg_rise = supply && match && !st.brg_clk;
      if (!supply) begin
         next_st.brg_clk = 1'b0;
      end else if (match) begin
         next_st.brg_clk = !st.brg_clk;
      end

      wtick = st.wmode[`BWT_WM_SOURCE] ? brg_rise : subclock_tick;

      // The prescaler runs with the enable bit alone, so the interval
      // interrupt works while the five-bit counter is held in clear.
      // eleven-bit prescaler
      if (!st.wmode[`BWT_WM_ENABLE]) begin
         next_st.wpre = 11'h000;
      end else if (wtick) begin
         next_st.wpre = st.wpre + 11'h001;
      end

      tap_sh   = `BWT_TAP_BASE + {1'b0, st.wmode[`BWT_WM_ISEL_HI:`BWT_WM_ISEL_LO]};
      tap_mask = bwt_tap_mask(tap_sh);
      tap_hit  = wtick && st.wmode[`BWT_WM_ENABLE] && (&(st.wpre | ~tap_mask));
      if (tap_hit) begin
         next_st.irq_wi = 1'b1;
      end

      div512   = wtick && (&st.wpre[`BWT_DIV512_MSB:0]);
      cnt_tick = st.wmode[`BWT_WM_PERIOD_HI] ? wtick : div512;

      if (!st.wmode[`BWT_WM_ENABLE] || !st.wmode[`BWT_WM_RUN]) begin
         next_st.wcnt = 5'h00;
      end else if (cnt_tick) begin
         next_st.wcnt = st.wcnt + 5'h01;
         if (st.wmode[`BWT_WM_PERIOD_LO]) begin
            next_st.irq_w = (st.wcnt[3:0] == 4'hf);
         end else begin
            next_st.irq_w = (st.wcnt == 5'h1f);
         end
      end

      // Read data and error answer are prepared in the setup phase so
      // that they come from flip-flops during the access phase.
      if (rd_setup) begin
         next_st.prdata  = 32'h00000000;
         next_st.pslverr = 1'b0;
         if (bwt_hit(paddr, `BWT_IDX_COMPARE)) begin
            next_st.prdata = {24'h000000, st.cmp};
         end else if (bwt_hit(paddr, `BWT_IDX_PRESCALE)) begin
            next_st.prdata = {24'h000000, st.ctl};
         end else if (bwt_hit(paddr, `BWT_IDX_WATCH_MODE)) begin
            next_st.prdata = {24'h000000, st.wmode};
         end else if (bwt_hit(paddr, `BWT_IDX_STATUS) && !pwrite) begin
            // Live counters for software that wants to see progress.
            next_st.prdata = {8'h00, st.wpre, st.wcnt, st.cnt};
         end else begin
            // Unmapped word, or a write to the read-only status word.
            next_st.pslverr = 1'b1;
         end
      end
   end

   // Register the whole state.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= BWT_STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Sequences used by the checks below.
   sequence s_match_seen;
      (st.state == BWT_ITV_RUN) && ctl_en && match;
   endsequence

   sequence s_reload_seen;
      interval_match_irq && (st.cnt == 8'h01);
   endsequence

   // A match gives the pulse and the reload in the next cycle.
   property p_match_irq;
      @(posedge mclk) disable iff (!resetn)
      s_match_seen |=> s_reload_seen;
   endproperty
   a_match_irq: assert property (p_match_irq)
      else $error("match did not raise irq and reload");

   // Compare zero rolls 255 to 0 with no interrupt.
   property p_zero_wrap;
      @(posedge mclk) disable iff (!resetn)
      itv_run && itv_tick && (st.cmp == 8'h00) && (st.cnt == 8'hff)
      |=> (st.cnt == 8'h00) && !interval_match_irq;
   endproperty
   a_zero_wrap: assert property (p_zero_wrap)
      else $error("compare zero did not extend to 256 counts");

   // After the single compare-one interrupt no further pulses come.
   property p_once;
      @(posedge mclk) disable iff (!resetn)
      (st.state == BWT_ITV_HELD) |=> !interval_match_irq;
   endproperty
   a_once: assert property (p_once)
      else $error("compare one interrupted more than once");

   // Disable returns to idle with the counter at one.
   property p_disable_clear;
      @(posedge mclk) disable iff (!resetn)
      !ctl_en |=> (st.cnt == 8'h01) && (st.state == BWT_ITV_IDLE);
   endproperty
   a_disable_clear: assert property (p_disable_clear)
      else $error("disable did not clear interval counter");

   // Without a count tick the counter holds.
   property p_hold;
      @(posedge mclk) disable iff (!resetn)
      itv_run && !itv_tick |=> $stable(st.cnt);
   endproperty
   a_hold: assert property (p_hold)
      else $error("interval counter moved without a count tick");

   // The derived clock rises after a match and stays low while not supplied.
   property p_derived;
      @(posedge mclk) disable iff (!resetn)
      (brg_rise |=> derived_main_clock) and (!supply |=> !derived_main_clock);
   endproperty
   a_derived: assert property (p_derived)
      else $error("derived clock wrong");

   // Clearing the enable bit empties prescaler and counter.
   property p_watch_clear;
      @(posedge mclk) disable iff (!resetn)
      !st.wmode[`BWT_WM_ENABLE] |=> (st.wpre == 11'h000) && (st.wcnt == 5'h00);
   endproperty
   a_watch_clear: assert property (p_watch_clear)
      else $error("watch enable low did not clear");

   // Clearing the run bit empties the five-bit counter.
   property p_cnt_clear;
      @(posedge mclk) disable iff (!resetn)
      !st.wmode[`BWT_WM_RUN] |=> (st.wcnt == 5'h00) && !watch_irq;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear)
      else $error("run bit low did not clear counter");

   // The shortest watch period ends at the sixteenth count, one cycle wide.
   property p_watch_16;
      @(posedge mclk) disable iff (!resetn)
      (st.wmode[3:0] == 4'hf) && wtick && (st.wcnt[3:0] == 4'hf)
      |=> watch_irq ##1 !watch_irq;
   endproperty
   a_watch_16: assert property (p_watch_16)
      else $error("watch irq missing at sixteen counts");

   // A tap of the prescaler gives the interval pulse.
   property p_tap;
      @(posedge mclk) disable iff (!resetn)
      tap_hit |=> watch_interval_irq;
   endproperty
   a_tap: assert property (p_tap)
      else $error("interval tap gave no irq");

   // With the derived source, the prescaler moves only on its rising edge.
   property p_source;
      @(posedge mclk) disable iff (!resetn)
      st.wmode[`BWT_WM_SOURCE] && st.wmode[`BWT_WM_ENABLE] && !brg_rise
      |=> $stable(st.wpre);
   endproperty
   a_source: assert property (p_source)
      else $error("watch prescaler moved without derived clock edge");

endmodule : bwt_timer

// ==== bwt_timer_tb.sv ====
// Self-checking testbench of the baud interval and watch timer.
`timescale 1ns/10ps
`include "bwt_defines.svh"
// Compares a design value with the expected one and reports a difference at once.
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module bwt_timer_tb;
   import bwt_pkg::*;

   localparam logic [11:0] A_CTL = 12'(`BWT_IDX_PRESCALE * 4);    // Prescale control.
   localparam logic [11:0] A_CMP = 12'(`BWT_IDX_COMPARE * 4);     // Compare value.
   localparam logic [11:0] A_WM  = 12'(`BWT_IDX_WATCH_MODE * 4);  // Watch mode.
   localparam logic [11:0] A_ST  = 12'(`BWT_IDX_STATUS * 4);      // Read-only status.

   logic        mclk;           // Main clock.
   logic        resetn;         // Reset, active low.
   logic        psel;           // APB select.
   logic        penable;        // APB access phase.
   logic        pwrite;         // APB direction.
   logic [11:0] paddr;          // APB address.
   logic [31:0] pwdata;         // APB write data.
   logic [3:0]  pstrb;          // APB strobes.
   logic        subclock_tick;  // Subclock enable pulse.
   logic [31:0] prdata;         // APB read data.
   logic        pready;         // APB ready.
   logic        pslverr;        // APB error.
   logic        irq_m;          // Interval match pulse.
   logic        irq_w;          // Watch period pulse.
   logic        irq_wi;         // Watch interval pulse.
   logic        dclk;           // Derived watch clock.
   int          fail_count;     // Mismatches seen.
   int          num_checks;     // Comparisons made.

   bwt_timer #(.PADDR_W(12)) u_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .subclock_tick(subclock_tick), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .interval_match_irq(irq_m), .watch_irq(irq_w), .watch_interval_irq(irq_wi),
      .derived_main_clock(dclk));

   // The clock runs at 100 MHz.
   always #5 mclk = ~mclk;

   // One APB transfer; it first lets an edge pass so back-to-back calls never collide.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // The access phase lasts until ready is seen high; only the watchdog ends a wait.
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Register write, discarding the answer.
   task wreg(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, {24'h000000, d}, rd, err);
   endtask : wreg

   // Register read.
   task rreg(input logic [11:0] a, output logic [31:0] rd, output logic err);
      apb(1'b0, a, 32'h00000000, rd, err);
   endtask : rreg

   // Picks one of the three interrupt outputs.
   function automatic logic pick(input int s);
      case (s)
         0: pick = irq_m;
         1: pick = irq_w;
         default: pick = irq_wi;
      endcase
   endfunction : pick

   // Waits for a pulse, then counts cycles up to the next; a lost pulse gives a huge count.
   task measure(input int s, output int cyc);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (pick(s) !== 1'b1 && n < 40000);
      cyc = 0;
      do begin
         @(posedge mclk);
         #1;
         cyc++;
         if (cyc == 1) `CHK("pulse width", 1'b0, pick(s))
      end while (pick(s) !== 1'b1 && cyc < 40000);
   endtask : measure

   // Counts pulses of one output over a fixed window; automatic so two copies may run at once.
   task automatic count_pulses(input int s, input int ncyc, output int cnt);
      cnt = 0;
      repeat (ncyc) begin
         @(posedge mclk);
         #1;
         if (pick(s) === 1'b1) cnt++;
      end
   endtask : count_pulses

   // Reset values, read-back and an unmapped access.
   task t_regs;
      logic [31:0] rd;
      logic        err;
      rreg(A_CMP, rd, err);
      `CHK("compare reset", 32'h00000000, rd)
      rreg(A_WM, rd, err);
      `CHK("mode reset", 32'h00000000, rd)
      rreg(A_ST, rd, err);
      `CHK("counter reset", 8'h01, rd[7:0])
      rreg(12'h2d0, rd, err);
      `CHK("unmapped error", 1'b1, err)
      wreg(A_CMP, 8'ha5);
      rreg(A_CMP, rd, err);
      `CHK("compare readback", 32'h000000a5, rd)
      wreg(A_WM, 8'h5c);
      rreg(A_WM, rd, err);
      `CHK("mode readback", 32'h0000005c, rd)
      wreg(A_WM, 8'h00);
   endtask : t_regs

   // Interval period for every prescale step, derived clock gating and a zero compare.
   task t_interval;
      logic [31:0] rd;
      logic        err;
      int          c;
      for (int m = 0; m < 5; m++) begin
         wreg(A_CMP, (m == 4) ? 8'h00 : 8'h03);
         wreg(A_CTL, {3'b000, 1'(m % 2), 2'b00, 2'(m % 4)});
         wreg(A_CTL, {3'b100, 1'(m % 2), 2'b00, 2'(m % 4)});
         measure(0, c);
         `CHK("interval period", (m == 4) ? 256 : (3 << m), c)
         // The third match leaves a supplied derived clock high; a gated one stays low.
         do begin
            @(posedge mclk);
            #1;
         end while (irq_m !== 1'b1);
         `CHK("derived clock", (m % 2 == 1) ? 1'b0 : 1'b1, dclk)
         wreg(A_CTL, 8'h00);
         rreg(A_ST, rd, err);
         `CHK("counter cleared", 8'h01, rd[7:0])
      end
   endtask : t_interval

   // A compare of one raises a single interrupt.
   task t_once;
      int n;
      wreg(A_CMP, 8'h01);
      wreg(A_CTL, 8'h80);
      count_pulses(0, 100, n);
      `CHK("single interrupt", 1, n)
      wreg(A_CTL, 8'h00);
   endtask : t_once

   // Watch and interval periods together on the subclock, over a table of settings.
   task t_watch;
      logic [31:0] rd;
      logic        err;
      int          c;
      logic [2:0]  ks [4] = '{3'd0, 3'd3, 3'd7, 3'd5};
      logic [1:0]  ps [4] = '{2'd3, 2'd2, 2'd1, 2'd0};
      int          wp [4] = '{16, 32, 8192, 16384};
      subclock_tick <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wreg(A_WM, {1'b0, ks[i], ps[i], 2'b00});
         wreg(A_WM, {1'b0, ks[i], ps[i], 2'b11});
         measure(2, c);
         `CHK("watch interval period", 16 << ks[i], c)
         measure(1, c);
         `CHK("watch period", wp[i], c)
         wreg(A_WM, 8'h00);
         rreg(A_ST, rd, err);
         `CHK("watch counters cleared", 16'h0000, rd[23:8])
      end
   endtask : t_watch

   // The run bit gates the counter while the prescaler keeps going.
   task t_run;
      logic [31:0] rd;
      logic        err;
      int          n;
      int          c_wi;  // Interval pulses seen in the run-bit window.
      wreg(A_WM, 8'h0c);
      wreg(A_WM, 8'h0d);
      fork
         count_pulses(1, 72, n);
         count_pulses(2, 72, c_wi);
      join
      `CHK("stopped counter", 0, n)
      `CHK("interval without run", 4, c_wi)
      rreg(A_ST, rd, err);
      `CHK("counter held clear", 5'h00, rd[12:8])
      wreg(A_WM, 8'h0f);
      count_pulses(1, 72, n);
      `CHK("running counter", 4, n)
      wreg(A_WM, 8'h00);
      subclock_tick <= 1'b0;
   endtask : t_run

   // The top mode bit moves the watch clock to the derived main clock.
   task t_source;
      int c;
      // N two halves to one, m one
      wreg(A_CMP, 8'h01);
      wreg(A_CTL, 8'h01);
      wreg(A_CTL, 8'h81);
      wreg(A_WM, 8'h8c);
      wreg(A_WM, 8'h8f);
      measure(1, c);
      `CHK("derived source period", 64, c)
      wreg(A_WM, 8'h00);
      wreg(A_CTL, 8'h00);
   endtask : t_source

   // Prints the counts and the verdict, then ends the run.
   task results;
      $display("Checks made %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   // Main sequence; all inputs get a value at time zero.
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'h1;
      subclock_tick = 1'b0;
      fail_count = 0;
      num_checks = 0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      t_regs();
      t_interval();
      t_once();
      t_watch();
      t_run();
      t_source();
      results();
   end

   // A hang is cut short well beyond the roughly 51000 cycles the tests need.
   initial begin
      repeat (90000) @(posedge mclk);
      fail_count++;
      results();
   end

endmodule : bwt_timer_tb
